// ---- semiflash_adc_pipeline_timing.sv ----
/*
 * Cycle model of the digital timing of an 8-bit two-step converter: sampling,
 * upper and interleaved lower resolution, merge, a word FIFO and the output bus.
 * Assumes the quantised input level arrives from a pin and the capture logic
 * sits on the same reference clock.
 */
// How it works
// - Each conversion falling edge captures input into upper and current lower bank.
// - Upper bank resolves high nibble on the next rising edge.
// - Lower bank resolves low nibble one clock later, reference chosen by upper.
// - Halves merge and go onto output bus one clock after low half.
// - Output appears two and a half conversion periods after sampling.
// - Samples alternate between the two lower banks, one word per clock.
// - Upper starts every fall; lower banks convert in the two following cycles.
// - Two non-overlapping phases, sampling and comparison, come from the clock.
// - In comparison each comparator resolves against its tap reference level.
// - Output is straight binary: bottom gives 0, top 255, 128 only MSB.
module semiflash_adc_pipeline_timing
    import semiflash_pkg::*;
#(
    parameter int HALF_LEN = HALF_CYCLES,
    parameter int DEPTH = FIFO_DEPTH
) (
    // Clock, reset and freeze
    input wire logic ref_clk,
    input wire logic reset_n,
    input wire logic clk_en,
    // Quantised analog level from the pin
    input wire logic [CODE_W-1:0] analog_level,
    // Output bus towards capture logic
    input wire logic capture_ready,
    output logic [CODE_W-1:0] data_out,
    output logic data_valid,
    output logic overrun,
    // Internal phases
    output logic sample_phase,
    output logic compare_phase
);

    localparam int HW = (HALF_LEN > 1) ? $clog2(HALF_LEN) : 1;

    // ==========================================================================
    // Declarations
    phase_t phase_ff, nxt_phase;
    logic [HW-1:0] half_ff, nxt_half;
    logic half_last, fall, rise;
    logic [CODE_W-1:0] lvl_meta_ff, lvl_sync_ff;
    logic sel_ff, nxt_sel;
    logic [1:0] capv_ff, nxt_capv;
    logic pv_ff, nxt_pv;
    logic [NIB_W-1:0] pu_ff, nxt_pu;
    logic pb_ff, nxt_pb;
    logic ovr_ff, nxt_ovr;
    logic dv_ff, nxt_dv;
    logic [CODE_W-1:0] data_ff, nxt_data;
    logic cap_a, cap_b, res_a, res_b;
    logic [NIB_W-1:0] upper_res, lower_res_a, lower_res_b, push_lower;
    logic [CODE_W-1:0] lower_base;
    nibble_pair_t fifo_in, fifo_out;
    logic fifo_in_ready, fifo_out_valid, load;

    // ==========================================================================
    // Conversion clock and its two phases
    // The phase register is one-hot, so the sampling and comparison phases can
    // never overlap; the price is that a gap between them is not modelled.
    assign half_last = half_ff == HW'(HALF_LEN - 1);
    assign fall = clk_en && half_last && (phase_ff == PH_COMPARE);
    assign rise = clk_en && half_last && (phase_ff == PH_SAMPLE);

    always_comb begin
        nxt_phase = phase_ff;
        nxt_half = half_ff;
        if (clk_en) begin
            if (half_last) begin
                nxt_half = '0;
                case (phase_ff)
                    PH_SAMPLE: begin
                        nxt_phase = PH_COMPARE;
                    end
                    PH_COMPARE: begin
                        nxt_phase = PH_SAMPLE;
                    end
                    default: begin
                        nxt_phase = PH_COMPARE;
                    end
                endcase
            end else begin
                nxt_half = half_ff + HW'(1);
            end
        end
    end

    always_ff @(posedge ref_clk) begin
        if (!reset_n) begin
            phase_ff <= PH_COMPARE;
            half_ff <= '0;
        end else begin
            phase_ff <= nxt_phase;
            half_ff <= nxt_half;
        end
    end

    assign sample_phase = phase_ff[0];
    assign compare_phase = phase_ff[1];

    // ==========================================================================
    // Input synchroniser
    // The pin level changes without regard to our clock, so two stages come first.
    always_ff @(posedge ref_clk) begin
        if (!reset_n) begin
            lvl_meta_ff <= RST_CODE;
            lvl_sync_ff <= RST_CODE;
        end else if (clk_en) begin
            lvl_meta_ff <= analog_level;
            lvl_sync_ff <= lvl_meta_ff;
        end
    end

    // ==========================================================================
    // Comparator banks
    assign cap_a = fall && !sel_ff;
    assign cap_b = fall && sel_ff;
    // The bank resolved at a rise is the one captured three half periods before.
    assign res_a = rise && !sel_ff;
    assign res_b = rise && sel_ff;
    assign lower_base = {upper_res, RST_NIB};

    comparator_bank #(
        .TAPS(TAP_COUNT)
    ) u_upper_bank (
        .ref_clk(ref_clk),
        .reset_n(reset_n),
        .capture(fall),
        .resolve(rise),
        .level(lvl_sync_ff),
        .base(UPPER_TAP_BASE),
        .step(UPPER_TAP_STEP),
        .result(upper_res)
    );

    comparator_bank #(
        .TAPS(TAP_COUNT)
    ) lower_comparator_bank_a (
        .ref_clk(ref_clk),
        .reset_n(reset_n),
        .capture(cap_a),
        .resolve(res_a),
        .level(lvl_sync_ff),
        .base(lower_base),
        .step(LOWER_TAP_STEP),
        .result(lower_res_a)
    );

    comparator_bank #(
        .TAPS(TAP_COUNT)
    ) lower_comparator_bank_b (
        .ref_clk(ref_clk),
        .reset_n(reset_n),
        .capture(cap_b),
        .resolve(res_b),
        .level(lvl_sync_ff),
        .base(lower_base),
        .step(LOWER_TAP_STEP),
        .result(lower_res_b)
    );

    // ==========================================================================
    // Bank rotation and merge
    always_comb begin
        nxt_sel = sel_ff;
        nxt_capv = capv_ff;
        nxt_pv = pv_ff;
        nxt_pu = pu_ff;
        nxt_pb = pb_ff;
        nxt_ovr = ovr_ff;
        if (fall) begin
            nxt_sel = ~sel_ff;
            nxt_capv[sel_ff] = 1'b1;
        end
        if (clk_en && pv_ff) begin
            nxt_pv = 1'b0;
            // A full FIFO means the capture side stalled too long; the word is lost.
            if (!fifo_in_ready) begin
                nxt_ovr = 1'b1;
            end
        end
        if (rise && capv_ff[sel_ff]) begin
            nxt_pv = 1'b1;
            nxt_pu = upper_res;
            nxt_pb = sel_ff;
        end
    end

    always_ff @(posedge ref_clk) begin
        if (!reset_n) begin
            sel_ff <= 1'b0;
            capv_ff <= 2'h0;
            pv_ff <= 1'b0;
            pu_ff <= RST_NIB;
            pb_ff <= 1'b0;
            ovr_ff <= 1'b0;
        end else begin
            sel_ff <= nxt_sel;
            capv_ff <= nxt_capv;
            pv_ff <= nxt_pv;
            pu_ff <= nxt_pu;
            pb_ff <= nxt_pb;
            ovr_ff <= nxt_ovr;
        end
    end

    assign push_lower = pb_ff ? lower_res_b : lower_res_a;
    assign fifo_in = '{upper_nibble_result: pu_ff, lower_nibble_result: push_lower};

    word_fifo #(
        .W($bits(nibble_pair_t)),
        .DEPTH(DEPTH)
    ) u_word_fifo (
        .ref_clk(ref_clk),
        .reset_n(reset_n),
        .clk_en(clk_en),
        .in_valid(pv_ff),
        .in_ready(fifo_in_ready),
        .in_data(fifo_in),
        .out_valid(fifo_out_valid),
        .out_ready(load),
        .out_data(fifo_out)
    );

    // ==========================================================================
    // Output bus
    // Words only move onto the bus on a rising edge, which keeps the latency fixed.
    assign load = rise && fifo_out_valid && (!dv_ff || capture_ready);

    always_comb begin
        nxt_dv = dv_ff;
        nxt_data = data_ff;
        if (clk_en && dv_ff && capture_ready) begin
            nxt_dv = 1'b0;
        end
        if (load) begin
            nxt_dv = 1'b1;
            nxt_data = fifo_out;
        end
    end

    always_ff @(posedge ref_clk) begin
        if (!reset_n) begin
            dv_ff <= 1'b0;
            data_ff <= RST_CODE;
        end else begin
            dv_ff <= nxt_dv;
            data_ff <= nxt_data;
        end
    end

    assign data_out = data_ff;
    assign data_valid = dv_ff;
    assign overrun = ovr_ff;

    // ==========================================================================
    // Checks
    // The timing checks assume the default half period of one reference cycle.
    default clocking @(posedge ref_clk); endclocking
    default disable iff (!reset_n);

    sequence s_fall_rise;
        fall ##1 rise;
    endsequence

    sequence s_lower_done;
        fall ##1 rise ##1 fall ##1 rise;
    endsequence

    sequence s_top_level;
        (clk_en && lvl_sync_ff == CODE_TOP)[*5] ##1 pv_ff;
    endsequence

    sequence s_mid_level;
        (clk_en && lvl_sync_ff == CODE_MID)[*5] ##1 pv_ff;
    endsequence

    AST_PHASE_ONEHOT: assert property ($onehot(phase_ff))
        else $error("phases overlap or vanish");

    AST_PHASE_SWAP: assert property ((clk_en && half_last && sample_phase) |=>
        (compare_phase && !sample_phase))
        else $error("sampling phase did not hand over to comparison");

    AST_BANK_ALTERNATE: assert property (fall |=> sel_ff != $past(sel_ff))
        else $error("lower banks did not alternate");

    AST_UPPER_SETTLE: assert property (s_fall_rise |=>
        upper_res == 4'($past(lvl_sync_ff, 2) >> 4))
        else $error("upper nibble wrong one rise after sampling");

    AST_LOWER_SETTLE: assert property (s_lower_done |=>
        (pv_ff && fifo_in == $past(lvl_sync_ff, 4)))
        else $error("merged code wrong after lower resolution");

    AST_LOWER_TURN: assert property ((rise && capv_ff[sel_ff]) |=>
        (pv_ff && pb_ff == $past(sel_ff)))
        else $error("wrong lower bank resolved");

    AST_MERGE_TO_BUS: assert property (load |=>
        (data_valid && data_out == $past(fifo_out)))
        else $error("merged word not driven on the bus");

    AST_LATENCY: assert property ((fall && !pv_ff && !fifo_out_valid && !dv_ff) ##1
        (clk_en && !dv_ff)[*5] |=> (data_valid && data_out == $past(lvl_sync_ff, 6)))
        else $error("output not two and a half periods after sampling");

    AST_CODE_TOP: assert property (s_top_level |-> fifo_in == CODE_TOP)
        else $error("top reference did not give full code");

    AST_CODE_MID: assert property (s_mid_level |-> fifo_in == CODE_MID)
        else $error("midscale did not give only the top bit");

    AST_OVERRUN_STICKY: assert property ((clk_en && pv_ff && !fifo_in_ready) |=>
        overrun [*2])
        else $error("lost word not flagged");

    AST_FREEZE: assert property (!clk_en |=> ($stable(phase_ff) && $stable(data_ff)))
        else $error("state moved while the clock enable was low");

endmodule // semiflash_adc_pipeline_timing

// ---- semiflash_pkg.sv ----
/*
 * Shared constants, types and timing figures for the two-step converter timing model.
 * Assumes one reference clock at 20 MHz and a conversion clock of half that rate.
 */
package semiflash_pkg;

    // ==========================================================================
    // Code layout
    localparam int CODE_W = 8;
    localparam int NIB_W = 4;
    localparam int TAP_COUNT = 15;
    localparam logic [7:0] CODE_BOTTOM = 8'h00;
    localparam logic [7:0] CODE_TOP = 8'hFF;
    localparam logic [7:0] CODE_MID = 8'h80;
    localparam logic [7:0] UPPER_TAP_BASE = 8'h00;
    localparam logic [7:0] UPPER_TAP_STEP = 8'h10;
    localparam logic [7:0] LOWER_TAP_STEP = 8'h01;

    // ==========================================================================
    // Reset values
    localparam logic [7:0] RST_CODE = 8'h00;
    localparam logic [3:0] RST_NIB = 4'h0;

    // ==========================================================================
    // Timing
    localparam int REF_CLK_PERIOD_NS = 50;
    localparam int CONV_PERIOD_NS = 100;
    localparam int HALF_RAW = CONV_PERIOD_NS / (2 * REF_CLK_PERIOD_NS);
    localparam int HALF_CYCLES = (HALF_RAW > 0) ? HALF_RAW : 1;
    // Two and a half conversion periods, counted in half periods.
    localparam int LATENCY_HALF_PERIODS = 5;
    localparam int LATENCY_CYCLES = LATENCY_HALF_PERIODS * HALF_CYCLES;
    localparam int FIFO_DEPTH = 8;

    // ==========================================================================
    // Types
    typedef enum logic [1:0] {
        PH_SAMPLE = 2'b01,
        PH_COMPARE = 2'b10
    } phase_t;

    typedef struct packed {
        logic [3:0] upper_nibble_result;
        logic [3:0] lower_nibble_result;
    } nibble_pair_t;

endpackage

// ---- comparator_bank.sv ----
/*
 * One comparator bank: holds a sample and resolves it against a ladder of taps.
 * Assumes capture and resolve are single-cycle strobes already gated by the clock enable.
 */
module comparator_bank
    import semiflash_pkg::*;
#(
    parameter int TAPS = TAP_COUNT
) (
    // Clock and reset
    input wire logic ref_clk,
    input wire logic reset_n,
    // Strobes
    input wire logic capture,
    input wire logic resolve,
    // Levels
    input wire logic [CODE_W-1:0] level,
    input wire logic [CODE_W-1:0] base,
    input wire logic [CODE_W-1:0] step,
    // Result
    output logic [NIB_W-1:0] result
);

    logic [CODE_W-1:0] held_ff;
    logic [CODE_W-1:0] nxt_held;
    logic [NIB_W-1:0] result_ff;
    logic [NIB_W-1:0] nxt_result;
    logic [CODE_W:0] tap;
    logic [NIB_W-1:0] count;

    // ==========================================================================
    // Sampling and comparison
    always_comb begin
        tap = '0;
        count = '0;
        nxt_held = held_ff;
        nxt_result = result_ff;
        if (capture) begin
            nxt_held = level;
        end
        // Each tap is one comparator; the ones that trip form a thermometer code.
        for (int k = 1; k <= TAPS; k++) begin
            tap = {1'b0, base} + 9'(k) * {1'b0, step};
            if ({1'b0, held_ff} >= tap) begin
                count = count + 4'h1;
            end
        end
        if (resolve) begin
            nxt_result = count;
        end
    end

    always_ff @(posedge ref_clk) begin
        if (!reset_n) begin
            held_ff <= RST_CODE;
            result_ff <= RST_NIB;
        end else begin
            held_ff <= nxt_held;
            result_ff <= nxt_result;
        end
    end

    assign result = result_ff;

    // ==========================================================================
    // Checks
    default clocking @(posedge ref_clk); endclocking
    default disable iff (!reset_n);

    AST_BANK_CAPTURE: assert property (capture |=> held_ff == $past(level))
        else $error("bank did not hold the sampled level");

    AST_BANK_ZERO: assert property (resolve |=> ((result_ff == RST_NIB) ==
        ({1'b0, $past(held_ff)} < {1'b0, $past(base)} + {1'b0, $past(step)})))
        else $error("bank result disagrees with first tap");

endmodule // comparator_bank

// ---- word_fifo.sv ----
/*
 * Small synchronous FIFO with valid and ready on both sides.
 * Assumes one clock; the clock enable freezes pointers and storage.
 */
module word_fifo #(
    parameter int W = 8,
    parameter int DEPTH = 8
) (
    // Clock, reset and freeze
    input wire logic ref_clk,
    input wire logic reset_n,
    input wire logic clk_en,
    // Fill side
    input wire logic in_valid,
    output logic in_ready,
    input wire logic [W-1:0] in_data,
    // Drain side
    output logic out_valid,
    input wire logic out_ready,
    output logic [W-1:0] out_data
);

    localparam int PW = (DEPTH > 1) ? $clog2(DEPTH) : 1;
    localparam int CW = $clog2(DEPTH + 1);

    logic [W-1:0] mem_ff [DEPTH];
    logic [PW-1:0] wr_ff, nxt_wr, rd_ff, nxt_rd;
    logic [CW-1:0] cnt_ff, nxt_cnt;
    logic push, pop;

    // ==========================================================================
    // Pointers and count
    always_comb begin
        in_ready = cnt_ff != CW'(DEPTH);
        out_valid = cnt_ff != '0;
        out_data = mem_ff[rd_ff];
        push = clk_en && in_valid && in_ready;
        pop = clk_en && out_valid && out_ready;
        nxt_wr = wr_ff;
        nxt_rd = rd_ff;
        nxt_cnt = cnt_ff;
        if (push) begin
            nxt_wr = (wr_ff == PW'(DEPTH - 1)) ? '0 : wr_ff + PW'(1);
        end
        if (pop) begin
            nxt_rd = (rd_ff == PW'(DEPTH - 1)) ? '0 : rd_ff + PW'(1);
        end
        if (push && !pop) begin
            nxt_cnt = cnt_ff + CW'(1);
        end else if (pop && !push) begin
            nxt_cnt = cnt_ff - CW'(1);
        end
    end

    always_ff @(posedge ref_clk) begin
        if (!reset_n) begin
            wr_ff <= '0;
            rd_ff <= '0;
            cnt_ff <= '0;
        end else begin
            wr_ff <= nxt_wr;
            rd_ff <= nxt_rd;
            cnt_ff <= nxt_cnt;
        end
    end

    // Storage needs no reset; a word is only read after it was written.
    always_ff @(posedge ref_clk) begin
        if (push) begin
            mem_ff[wr_ff] <= in_data;
        end
    end

endmodule // word_fifo

// ---- capture_model.sv ----
/*
 * Behavioural model of the capture logic that reads the converter's output bus.
 * Assumes it shares the reference clock and honours the clock enable of the block.
 */
module capture_model (
    // Clock, reset and freeze
    input wire logic ref_clk,
    input wire logic reset_n,
    input wire logic clk_en,
    // Pace set by the bench: 0 prompt, 1 every other cycle, 2 stalled
    input wire logic [1:0] pace,
    // Output bus from the converter
    input wire logic [7:0] data_out,
    input wire logic data_valid,
    output logic capture_ready
);
    timeunit 1ns;
    timeprecision 100ps;

    // ==========================================================================
    // Pacing and capture
    logic [7:0] got[$];
    logic toggle_ff;

    // Ready is only ever changed just after an edge, so a take is never half seen.
    assign capture_ready = (pace == 2'h0) ? 1'b1 : ((pace == 2'h1) ? toggle_ff : 1'b0);

    always @(posedge ref_clk) begin
        if (!reset_n) begin
            toggle_ff <= 1'b0;
        end else begin
            toggle_ff <= ~toggle_ff;
            // Words are logged on the same edge the handshake completes.
            if (clk_en && data_valid === 1'b1 && capture_ready) begin
                got.push_back(data_out);
            end
        end
    end
endmodule // capture_model

// ---- semiflash_adc_pipeline_timing_tb.sv ----
/*
 * Self-checking bench for the two-step converter timing model.
 * Assumes the design package and the capture model are compiled first.
 */
module semiflash_adc_pipeline_timing_tb
    import semiflash_pkg::*;
;
    timeunit 1ns;
    timeprecision 100ps;

    // ==========================================================================
    // Clock, stimulus and bookkeeping
    logic ref_clk = 1'b0;
    logic reset_n = 1'b0;
    logic clk_en = 1'b1;
    logic [7:0] analog_level = 8'h00;
    logic [1:0] pace = 2'h0;
    logic capture_ready;
    logic [7:0] data_out;
    logic data_valid;
    logic overrun;
    logic sample_phase;
    logic compare_phase;
    int fail_count = 0;
    int checks_done = 0;
    int cycles = 0;

    always #25 ref_clk = ~ref_clk;

    semiflash_adc_pipeline_timing #(.HALF_LEN(1), .DEPTH(FIFO_DEPTH)) uut (
        .ref_clk(ref_clk), .reset_n(reset_n), .clk_en(clk_en),
        .analog_level(analog_level), .capture_ready(capture_ready),
        .data_out(data_out), .data_valid(data_valid), .overrun(overrun),
        .sample_phase(sample_phase), .compare_phase(compare_phase));

    capture_model cap (
        .ref_clk(ref_clk), .reset_n(reset_n), .clk_en(clk_en), .pace(pace),
        .data_out(data_out), .data_valid(data_valid), .capture_ready(capture_ready));

    // ==========================================================================
    // Shared tasks
    task automatic tick(input int n);
        repeat (n) @(posedge ref_clk);
        #1;
    endtask

    task automatic check(input string what, input logic [7:0] seen, input logic [7:0] exp);
        checks_done++;
        if (seen !== exp) begin
            fail_count++;
            $display("ERROR %s expected %h seen %h", what, exp, seen);
        end
    endtask

    task automatic close_out;
        $display("checks %0d mismatches %0d", checks_done, fail_count);
        if (fail_count == 0 && checks_done > 0) begin
            $display("ALL TESTS PASSED");
        end else begin
            $display("TESTS FAILED");
        end
        $finish;
    endtask

    task automatic do_reset;
        reset_n = 1'b0;
        tick(5);
        check("reset data_out", data_out, RST_CODE);
        check("reset data_valid", data_valid, 8'h00);
        check("reset overrun", overrun, 8'h00);
        check("reset compare_phase", compare_phase, 8'h01);
        check("reset sample_phase", sample_phase, 8'h00);
        reset_n = 1'b1;
    endtask

    // ==========================================================================
    // Scenarios
    task automatic t_latency;
        int n;
        analog_level = 8'h3C;
        do_reset;
        n = 0;
        while (data_valid !== 1'b1 && n < 20) begin
            tick(1);
            n++;
        end
        check("edges to first word", n[7:0], 8'h06);
        tick(11);
        analog_level = 8'hC3;
        n = 0;
        while (!(data_valid === 1'b1 && data_out === 8'hC3) && n < 20) begin
            tick(1);
            n++;
        end
        // Two synchroniser edges, one or two edges to the capturing fall, then five.
        check("step latency in range", {7'h00, n >= 8 && n <= 9}, 8'h01);
        $display("test latency done");
    endtask

    task automatic t_codes;
        logic [7:0] codes[8];
        codes = '{CODE_BOTTOM, CODE_TOP, CODE_MID, 8'h7F, 8'h5A, 8'hA5, 8'h0F, 8'hF0};
        foreach (codes[i]) begin
            analog_level = codes[i];
            tick(12);
            cap.got.delete();
            tick(8);
            check("words per eight cycles", 8'(cap.got.size()), 8'h04);
            foreach (cap.got[j]) begin
                check("code value", cap.got[j], codes[i]);
            end
        end
        $display("test codes done");
    endtask

    task automatic t_ramp;
        logic [7:0] e;
        // Each level lasts one conversion period, so every sample is distinct and
        // a swapped or stale lower bank shows as a broken sequence.
        for (int i = 0; i < 24; i++) begin
            if (i == 8) begin
                cap.got.delete();
            end
            analog_level = 8'hF4 + 8'(i);
            tick(2);
        end
        check("ramp word count", 8'(cap.got.size()), 8'h10);
        for (int j = 0; j + 1 < cap.got.size(); j++) begin
            e = cap.got[j] + 8'h01;
            check("ramp next word", cap.got[j + 1], e);
        end
        $display("test ramp done");
    endtask

    task automatic t_phase;
        logic p;
        for (int i = 0; i < 8; i++) begin
            check("phases exclusive", sample_phase ^ compare_phase, 8'h01);
            p = compare_phase;
            tick(1);
            check("phase toggles", compare_phase, {7'h00, !p});
        end
        $display("test phase done");
    endtask

    task automatic t_freeze;
        logic [7:0] d;
        logic v;
        logic p;
        pace = 2'h2;
        tick(6);
        clk_en = 1'b0;
        pace = 2'h0;
        d = data_out;
        v = data_valid;
        p = compare_phase;
        tick(6);
        check("frozen data_out", data_out, d);
        check("frozen data_valid", data_valid, v);
        check("frozen phase", compare_phase, p);
        clk_en = 1'b1;
        tick(20);
        $display("test freeze done");
    endtask

    task automatic t_fifo;
        logic [7:0] d;
        analog_level = 8'h66;
        // The freeze test leaves a permanent backlog in the FIFO, since words
        // leave no faster than they arrive; start from an empty pipeline.
        do_reset;
        tick(14);
        cap.got.delete();
        pace = 2'h2;
        tick(1);
        d = data_out;
        tick(12);
        check("stalled word valid", data_valid, 8'h01);
        check("stalled word stands", data_out, d);
        check("no overrun yet", overrun, 8'h00);
        tick(60);
        check("overrun after fill", overrun, 8'h01);
        pace = 2'h1;
        tick(40);
        pace = 2'h0;
        tick(20);
        check("overrun sticky", overrun, 8'h01);
        check("drained enough", {7'h00, cap.got.size() >= 9}, 8'h01);
        foreach (cap.got[j]) begin
            check("drained word", cap.got[j], 8'h66);
        end
        do_reset;
        tick(1);
        check("overrun cleared", overrun, 8'h00);
        $display("test fifo done");
    endtask

    // ==========================================================================
    // Main sequence and hang guard
    always @(posedge ref_clk) begin
        cycles++;
        if (cycles == 3000) begin
            fail_count++;
            $display("ERROR timeout expected finish seen hang");
            close_out;
        end
    end

    initial begin
        t_latency;
        t_codes;
        t_ramp;
        t_phase;
        t_freeze;
        t_fifo;
        close_out;
    end
endmodule // semiflash_adc_pipeline_timing_tb
